// ===== inc/impse_pkg.sv
// constants, types and helpers shared by the exec unit, its address leaf and the bench
// assumes one 10 MHz pclk domain and a 4096-byte byte-wide data space
package impse_pkg;

   // apb register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STAT_OFS   = 8'h04;
   localparam logic [7:0] IWORD0_OFS = 8'h08;
   localparam logic [7:0] IWORD1_OFS = 8'h0C;
   localparam logic [7:0] ACC_OFS    = 8'h10;
   localparam logic [7:0] FLAGS_OFS  = 8'h14;
   localparam logic [7:0] FP_OFS     = 8'h18;
   localparam logic [7:0] BANK_OFS   = 8'h1C;
   localparam logic [7:0] MADDR_OFS  = 8'h20;
   localparam logic [7:0] MDATA_OFS  = 8'h24;

   // field positions
   localparam int CTRL_EXT_BIT  = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ILL_BIT  = 1;
   localparam int STAT_NOP_BIT  = 2;

   // reset values
   localparam logic [7:0]  ACC_RST = 8'h00;
   localparam logic [11:0] FP_RST  = 12'h000;
   localparam logic [3:0]  BSR_RST = 4'h0;

   // opcode patterns
   localparam logic [5:0] SUB_OPC      = 6'h15;   // 0101 01
   localparam logic [8:0] MOVE_OPC     = 9'h1D7;  // 1110 1011 1
   localparam logic [3:0] MOVE_W2_OPC  = 4'hF;    // 1111
   localparam logic [7:0] PUSH_OPC     = 8'hEA;   // 1110 1010
   localparam logic [7:0] IDX_LIMIT    = 8'h5F;   // 95
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HI    = 4'hF;

   // indirect addressing register locations in the data space
   localparam logic [11:0] IND0_ADDR = 12'hFE0;
   localparam logic [11:0] IND1_ADDR = 12'hFE1;
   localparam logic [11:0] IND2_ADDR = 12'hFE2;

   // timing: one instruction cycle is four pclk edges (q1..q4)
   localparam int CLK_NS   = 100;
   localparam int ICYC_NS  = 400;
   localparam int Q_PER_IC = ICYC_NS / CLK_NS;
   localparam logic [1:0] Q_LAST = 2'(Q_PER_IC - 1);

   typedef enum logic [1:0] {
      OP_SUB  = 2'b00,
      OP_MOVE = 2'b01,
      OP_PUSH = 2'b10,
      OP_NOP  = 2'b11
   } impse_op_e;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } impse_state_e;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } impse_flags_s;

   typedef struct packed {
      logic [11:0] sub_addr;
      logic [11:0] src_addr;
      logic [11:0] dst_addr;
      logic        src_ind;
      logic        dst_ind;
   } impse_addr_s;

   function automatic logic impse_is_ind(input logic [11:0] a);
      return (a == IND0_ADDR) || (a == IND1_ADDR) || (a == IND2_ADDR);
   endfunction : impse_is_ind

endpackage : impse_pkg

// ===== sim/test_indexed_move_push_subtract_exec.sv
// self-checking bench for the subtract, indexed move and push exec unit
// assumes a zero-wait apb slave and instructions issued through iword0
`timescale 1ns/1ps
module test_indexed_move_push_subtract_exec;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic [31:0] rd;
   logic        err;
   int          error_cnt;
   int          n_checks;
   int          cyc;
   int          bcnt;

   impse_exec dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy));

   // 10 MHz clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // busy length per instruction and a hang limit well above the whole run
   always @(posedge pclk) begin
      cyc++;
      if (busy === 1'b1) bcnt++;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end

   task automatic results;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, impse_pkg::MADDR_OFS, {20'h0, a});
      apb(1'b1, impse_pkg::MDATA_OFS, {24'h0, d});
   endtask : mem_wr

   task automatic mem_chk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b1, impse_pkg::MADDR_OFS, {20'h0, a});
      apb(1'b0, impse_pkg::MDATA_OFS, 32'h0);
      chk(rd, {24'h0, e});
   endtask : mem_chk

   task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : reg_chk

   // poll status until idle, then check busy length and status bits
   task automatic done(input int n, input logic [31:0] st);
      do apb(1'b0, impse_pkg::STAT_OFS, 32'h0); while (rd[0] !== 1'b0);
      chk(rd, st);
      chk(bcnt, n);
   endtask : done

   task automatic issue(input logic [15:0] w0, input int n, input logic [31:0] st);
      bcnt = 0;
      apb(1'b1, impse_pkg::IWORD0_OFS, {16'h0, w0});
      chk(err, 1'b0);
      done(n, st);
   endtask : issue

   // preload acc, flags and operand; check result and n, z, c only
   task automatic sub_case(input logic [15:0] iw, input logic [11:0] ma, input logic [7:0] acc,
         input logic [7:0] mv, input logic [4:0] fl, input logic [7:0] res, input logic [4:0] ef);
      apb(1'b1, impse_pkg::ACC_OFS, {24'h0, acc});
      apb(1'b1, impse_pkg::FLAGS_OFS, {27'h0, fl});
      mem_wr(ma, mv);
      issue(iw, 4, 32'h0);
      if (iw[9]) mem_chk(ma, res);
      else reg_chk(impse_pkg::ACC_OFS, {24'h0, res});
      apb(1'b0, impse_pkg::FLAGS_OFS, 32'h0);
      chk(rd & 32'h15, {27'h0, ef});
   endtask : sub_case

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      error_cnt = 0;
      n_checks = 0;
      cyc = 0;
      bcnt = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      reg_chk(impse_pkg::ACC_OFS, {24'h0, impse_pkg::ACC_RST});
      reg_chk(impse_pkg::FP_OFS, {20'h0, impse_pkg::FP_RST});
      apb(1'b0, 8'h30, 32'h0);
      chk(err, 1'b1);
      // banked and access-bank subtract, extended set off
      apb(1'b1, impse_pkg::BANK_OFS, 32'h1);
      sub_case(16'h5720, 12'h120, 8'h02, 8'h03, 5'h01, 8'hFF, 5'h10);
      sub_case(16'h5520, 12'h120, 8'h05, 8'h02, 5'h01, 8'h03, 5'h01);
      sub_case(16'h5720, 12'h120, 8'h02, 8'h01, 5'h00, 8'h00, 5'h05);
      sub_case(16'h5420, 12'h020, 8'h05, 8'h02, 5'h01, 8'h03, 5'h01);
      // indexed literal offset at both sides of the 95 limit
      apb(1'b1, impse_pkg::CTRL_OFS, 32'h1);
      apb(1'b1, impse_pkg::FP_OFS, 32'h200);
      sub_case(16'h545F, 12'h25F, 8'h05, 8'h02, 5'h01, 8'h03, 5'h01);
      sub_case(16'h5460, 12'hF60, 8'h05, 8'h02, 5'h01, 8'h03, 5'h01);
      // indexed move, flags preset to a marker value
      apb(1'b1, impse_pkg::FLAGS_OFS, 32'h0A);
      apb(1'b1, impse_pkg::FP_OFS, 32'h080);
      mem_wr(12'h085, 8'h33);
      mem_wr(12'h086, 8'h11);
      apb(1'b1, impse_pkg::IWORD1_OFS, 32'hFF86);
      issue(16'hEB85, 8, 32'h0);
      mem_chk(12'h086, 8'h33);
      mem_chk(12'h085, 8'h33);
      reg_chk(impse_pkg::FP_OFS, 32'h080);
      reg_chk(impse_pkg::FLAGS_OFS, 32'h0A);
      // largest offset reaching the top of the data space
      apb(1'b1, impse_pkg::FP_OFS, 32'hF80);
      mem_wr(12'hFFF, 8'h5A);
      apb(1'b1, impse_pkg::IWORD1_OFS, 32'hF000);
      issue(16'hEBFF, 8, 32'h0);
      mem_chk(12'hF80, 8'h5A);
      // source on an indirect register moves zero
      apb(1'b1, impse_pkg::FP_OFS, 32'hFA0);
      mem_wr(12'hFB0, 8'h55);
      apb(1'b1, impse_pkg::IWORD1_OFS, 32'hF010);
      issue(16'hEBC0, 8, 32'h0);
      mem_chk(12'hFB0, 8'h00);
      // destination on an indirect register is a nop
      mem_wr(12'hFB0, 8'h77);
      apb(1'b1, impse_pkg::IWORD1_OFS, 32'hF041);
      issue(16'hEB90, 8, 32'h4);
      mem_chk(12'hFB0, 8'h77);
      // wrong second word is refused
      apb(1'b1, impse_pkg::IWORD1_OFS, 32'h7010);
      issue(16'hEB90, 4, 32'h2);
      // two pushes back to back grow the stack downward
      apb(1'b1, impse_pkg::FP_OFS, 32'h1EC);
      issue(16'hEA08, 4, 32'h0);
      issue(16'hEAFF, 4, 32'h0);
      mem_chk(12'h1EC, 8'h08);
      mem_chk(12'h1EB, 8'hFF);
      reg_chk(impse_pkg::FP_OFS, 32'h1EA);
      reg_chk(impse_pkg::FLAGS_OFS, 32'h0A);
      // push with the extended set off, and a write while busy
      apb(1'b1, impse_pkg::CTRL_OFS, 32'h0);
      bcnt = 0;
      apb(1'b1, impse_pkg::IWORD0_OFS, 32'hEA11);
      apb(1'b1, impse_pkg::ACC_OFS, 32'h55);
      chk(err, 1'b1);
      done(4, 32'h2);
      reg_chk(impse_pkg::FP_OFS, 32'h1EA);
      results();
   end
endmodule : test_indexed_move_push_subtract_exec

// ===== verilog/impse_addr_gen.sv
// operand address generation for subtract and move; push uses the frame pointer directly
// assumes fields come from the held instruction words; purely combinational
`timescale 1ns/1ps
module impse_addr_gen (
   // machine state
   input  wire logic [11:0]        fp,
   input  wire logic [3:0]         bank_selector_register,
   input  wire logic               ext_en,
   // instruction fields
   input  wire logic [7:0]         f_addr,
   input  wire logic               a_bit,
   input  wire logic [6:0]         zs,
   input  wire logic [6:0]         zd,
   // result
   output impse_pkg::impse_addr_s  addr
);

   // file operand: indexed literal offset, access bank or banked
   always_comb begin
      addr = '0;
      if (!a_bit && ext_en && (f_addr <= impse_pkg::IDX_LIMIT)) begin
         addr.sub_addr = fp + {4'h0, f_addr};
      end else if (!a_bit) begin
         addr.sub_addr = (f_addr < impse_pkg::ACCESS_SPLIT) ? {4'h0, f_addr}
                                                              : {impse_pkg::ACCESS_HI, f_addr};
      end else begin
         addr.sub_addr = {bank_selector_register, f_addr};
      end
      // unsigned offsets, wrap inside the 4096-byte space
      addr.src_addr = fp + {5'h00, zs};
      addr.dst_addr = fp + {5'h00, zd};
      addr.src_ind  = impse_pkg::impse_is_ind(addr.src_addr);
      addr.dst_ind  = impse_pkg::impse_is_ind(addr.dst_addr);
   end

endmodule : impse_addr_gen

// ===== verilog/impse_data_mem.sv
// 4096 x 8 data memory, one write port and two asynchronous read ports
// assumes the caller never writes from two sources in one cycle
`timescale 1ns/1ps
module impse_data_mem (
   // clock
   input  wire logic        pclk,
   // write port
   input  wire logic        we,
   input  wire logic [11:0] waddr,
   input  wire logic [7:0]  wdata,
   // read ports
   input  wire logic [11:0] raddr_a,
   output logic      [7:0]  rdata_a,
   input  wire logic [11:0] raddr_b,
   output logic      [7:0]  rdata_b
);

   logic [7:0] mem [0:4095];

   // no reset on the array: contents are undefined until written
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata_a = mem[raddr_a];
   assign rdata_b = mem[raddr_b];

endmodule : impse_data_mem

// ===== verilog/impse_exec.sv
// execution unit for subtract-with-borrow, indexed move and push literal
// assumes an apb master on pclk; software loads words then writes iword0
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module impse_exec (
   // apb clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // status
   output logic             busy
);

   impse_pkg::impse_state_e state_r;
   impse_pkg::impse_op_e    op_r;
   impse_pkg::impse_flags_s flags_r;
   impse_pkg::impse_flags_s flags_nxt;
   impse_pkg::impse_addr_s  addr;
   impse_pkg::impse_op_e    op_dec;

   logic [15:0] ir0_r;
   logic [15:0] ir1_r;
   logic [7:0]  acc_r;
   logic [11:0] fp_r;
   logic [3:0]  bsr_r;
   logic [11:0] maddr_r;
   logic        ext_en_r;
   logic        ill_r;
   logic        nop_r;
   logic [1:0]  q_r;
   logic        cyc_r;
   logic [7:0]  opnd_r;
   logic [7:0]  res_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;

   logic        setup;
   logic        acc_wr;
   logic        acc_rd;
   logic        start;
   logic        last_q;
   logic        last_c;
   logic        refuse;
   logic [8:0]  sum;
   logic [4:0]  half;
   logic [7:0]  res_nxt;
   logic [11:0] exe_raddr;
   logic [7:0]  exe_rdata;
   logic [7:0]  apb_rdata;
   logic        mem_we;
   logic [11:0] mem_waddr;
   logic [7:0]  mem_wdata;
   logic        exe_we;
   logic [11:0] exe_waddr;
   logic [7:0]  exe_wdata;
   logic [31:0] rd_mux;
   logic        rd_hit;

   // apb phase decode; pready is registered so every access has one wait-free access cycle
   assign setup  = psel && !penable;
   assign acc_wr = psel && penable && pready_r && pwrite && !pslverr_r;
   assign acc_rd = psel && penable && pready_r && !pwrite;
   assign start  = acc_wr && (paddr == impse_pkg::IWORD0_OFS);

   // instruction decode on the held words; move and push need the extended set
   always_comb begin
      op_dec = impse_pkg::OP_NOP;
      if (ir0_r[15:10] == impse_pkg::SUB_OPC) begin
         op_dec = impse_pkg::OP_SUB;
      end else if (ext_en_r && ir0_r[15:7] == impse_pkg::MOVE_OPC
                   && ir1_r[15:12] == impse_pkg::MOVE_W2_OPC) begin
         op_dec = impse_pkg::OP_MOVE;
      end else if (ext_en_r && ir0_r[15:8] == impse_pkg::PUSH_OPC) begin
         op_dec = impse_pkg::OP_PUSH;
      end
   end

   impse_addr_gen u_addr (
      .fp     (fp_r),
      .bank_selector_register    (bsr_r),
      .ext_en (ext_en_r),
      .f_addr (ir0_r[7:0]),
      .a_bit  (ir0_r[8]),
      .zs     (ir0_r[6:0]),
      .zd     (ir1_r[6:0]),
      .addr   (addr)
   );

   // subtract w - f - borrow as w + ~f + c, two's complement
   assign sum     = {1'b0, acc_r} + {1'b0, ~opnd_r} + {8'h00, flags_r.c};
   assign half    = {1'b0, acc_r[3:0]} + {1'b0, ~opnd_r[3:0]} + {4'h0, flags_r.c};
   assign res_nxt = sum[7:0];
   always_comb begin
      flags_nxt.c  = sum[8];
      flags_nxt.dc = half[4];
      flags_nxt.z  = (res_nxt == 8'h00);
      flags_nxt.n  = res_nxt[7];
      flags_nxt.ov = (acc_r[7] != opnd_r[7]) && (res_nxt[7] != acc_r[7]);
   end

   // sequencer: four q phases per instruction cycle, two cycles for the move
   assign last_q = (q_r == impse_pkg::Q_LAST);
   assign last_c = (op_r == impse_pkg::OP_MOVE) ? cyc_r : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= impse_pkg::ST_IDLE;
         q_r     <= 2'h0;
         cyc_r   <= 1'b0;
      end else if (state_r == impse_pkg::ST_IDLE) begin
         q_r   <= 2'h0;
         cyc_r <= 1'b0;
         if (start) begin
            state_r <= impse_pkg::ST_RUN;
         end
      end else begin
         q_r <= q_r + 2'h1;
         if (last_q) begin
            cyc_r <= 1'b1;
            if (last_c) begin
               state_r <= impse_pkg::ST_IDLE;
            end
         end
      end
   end

   // decoded opcode is latched in q1 of the first cycle so that later words cannot disturb it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r <= impse_pkg::OP_NOP;
         ill_r <= 1'b0;
         nop_r <= 1'b0;
      end else if (state_r == impse_pkg::ST_IDLE && start) begin
         case (pwdata[15:10] == impse_pkg::SUB_OPC)
            1'b1:    op_r <= impse_pkg::OP_SUB;
            default: op_r <= impse_pkg::OP_NOP;
         endcase
         nop_r <= 1'b0;
      end else if (state_r == impse_pkg::ST_RUN && q_r == 2'h0 && !cyc_r) begin
         op_r  <= op_dec;                                                   // q1 decode
         ill_r <= (op_dec == impse_pkg::OP_NOP);
         nop_r <= (op_dec == impse_pkg::OP_MOVE) && addr.dst_ind;
      end
   end

   // q2 read: file operand or move source; indirect source gives 00h
   assign exe_raddr = (op_r == impse_pkg::OP_MOVE) ? addr.src_addr : addr.sub_addr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opnd_r <= 8'h00;
      end else if (state_r == impse_pkg::ST_RUN && !cyc_r && q_r == 2'h1) begin
         if (op_r == impse_pkg::OP_MOVE && addr.src_ind) begin
            opnd_r <= 8'h00;
         end else if (op_r == impse_pkg::OP_PUSH) begin
            opnd_r <= ir0_r[7:0];
         end else begin
            opnd_r <= exe_rdata;
         end
      end
   end

   // q3 process: result held for the q4 write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_r <= 8'h00;
      end else if (state_r == impse_pkg::ST_RUN && q_r == 2'h2) begin
         res_r <= (op_r == impse_pkg::OP_SUB) ? res_nxt : opnd_r;
      end
   end

   // q4 write to data memory: file result, moved byte or pushed literal
   always_comb begin
      exe_we    = 1'b0;
      exe_waddr = addr.sub_addr;
      exe_wdata = res_r;
      if (state_r == impse_pkg::ST_RUN && last_q) begin
         case (op_r)
            impse_pkg::OP_SUB: begin
               exe_we = ir0_r[9];
            end
            impse_pkg::OP_MOVE: begin
               exe_we    = cyc_r && !addr.dst_ind;
               exe_waddr = addr.dst_addr;
            end
            impse_pkg::OP_PUSH: begin
               exe_we    = 1'b1;
               exe_waddr = fp_r;
            end
            default: begin
               exe_we = 1'b0;
            end
         endcase
      end
   end

   // apb writes to the memory window are refused while busy, so no collision
   assign mem_we    = exe_we || (acc_wr && paddr == impse_pkg::MDATA_OFS);
   assign mem_waddr = exe_we ? exe_waddr : maddr_r;
   assign mem_wdata = exe_we ? exe_wdata : pwdata[7:0];

   impse_data_mem u_mem (
      .pclk    (pclk),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr_a (exe_raddr),
      .rdata_a (exe_rdata),
      .raddr_b (maddr_r),
      .rdata_b (apb_rdata)
   );

   // accumulator: subtract with d=0, or software write while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= impse_pkg::ACC_RST;
      end else if (state_r == impse_pkg::ST_RUN && last_q
                   && op_r == impse_pkg::OP_SUB && !ir0_r[9]) begin
         acc_r <= res_r;
      end else if (acc_wr && paddr == impse_pkg::ACC_OFS) begin
         acc_r <= pwdata[7:0];
      end
   end

   // status flags change only on subtract or a software write; move and push leave them alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= '0;
      end else if (state_r == impse_pkg::ST_RUN && q_r == 2'h2
                   && op_r == impse_pkg::OP_SUB) begin
         flags_r <= flags_nxt;
      end else if (acc_wr && paddr == impse_pkg::FLAGS_OFS) begin
         flags_r <= pwdata[4:0];
      end
   end

   // frame pointer: push decrements it after its write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fp_r <= impse_pkg::FP_RST;
      end else if (state_r == impse_pkg::ST_RUN && last_q && op_r == impse_pkg::OP_PUSH) begin
         fp_r <= fp_r - 12'h001;
      end else if (acc_wr && paddr == impse_pkg::FP_OFS) begin
         fp_r <= pwdata[11:0];
      end
   end

   // software-owned configuration and instruction words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_en_r <= 1'b0;
         bsr_r    <= impse_pkg::BSR_RST;
         maddr_r  <= 12'h000;
         ir0_r    <= 16'h0000;
         ir1_r    <= 16'h0000;
      end else if (acc_wr) begin
         case (paddr)
            impse_pkg::CTRL_OFS:   ext_en_r <= pwdata[impse_pkg::CTRL_EXT_BIT];
            impse_pkg::BANK_OFS:   bsr_r    <= pwdata[3:0];
            impse_pkg::MADDR_OFS:  maddr_r  <= pwdata[11:0];
            impse_pkg::IWORD0_OFS: ir0_r    <= pwdata[15:0];
            impse_pkg::IWORD1_OFS: ir1_r    <= pwdata[15:0];
            default:               ext_en_r <= ext_en_r;
         endcase
      end
   end

   // read mux, sampled in the setup cycle
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         impse_pkg::CTRL_OFS:   rd_mux = {31'h0, ext_en_r};
         impse_pkg::STAT_OFS:   rd_mux = {29'h0, nop_r, ill_r, state_r == impse_pkg::ST_RUN};
         impse_pkg::IWORD0_OFS: rd_mux = {16'h0000, ir0_r};
         impse_pkg::IWORD1_OFS: rd_mux = {16'h0000, ir1_r};
         impse_pkg::ACC_OFS:    rd_mux = {24'h00_0000, acc_r};
         impse_pkg::FLAGS_OFS:  rd_mux = {27'h000_0000, flags_r};
         impse_pkg::FP_OFS:     rd_mux = {20'h0_0000, fp_r};
         impse_pkg::BANK_OFS:   rd_mux = {28'h000_0000, bsr_r};
         impse_pkg::MADDR_OFS:  rd_mux = {20'h0_0000, maddr_r};
         impse_pkg::MDATA_OFS:  rd_mux = {24'h00_0000, apb_rdata};
         default:               rd_hit = 1'b0;
      endcase
   end

   // unmapped addresses and any write while an instruction runs end in pslverr
   assign refuse = !rd_hit || (pwrite && (state_r == impse_pkg::ST_RUN || start));

   // apb answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && refuse;
         if (setup && !pwrite && rd_hit) begin
            prdata_r <= rd_mux;
         end else if (acc_rd) begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign busy    = (state_r == impse_pkg::ST_RUN);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sub_one_cycle: assert property (start ##1 (op_dec == impse_pkg::OP_SUB)
      |-> busy [*4] ##1 !busy) else $error("subtract did not take four clocks");
   a_move_two_cycles: assert property (start ##1 (op_dec == impse_pkg::OP_MOVE)
      |-> busy [*8] ##1 !busy) else $error("move did not take eight clocks");
   a_borrow_flags: assert property ((busy && q_r == 2'h2 && op_r == impse_pkg::OP_SUB
      && {1'b0, acc_r} < {1'b0, opnd_r} + {8'h00, !flags_r.c}
      && {1'b0, opnd_r} + {8'h00, !flags_r.c} - {1'b0, acc_r} <= 9'h080)
      |=> !flags_r.c && flags_r.n)
      else $error("borrow did not clear carry or set n");
   a_pos_flags: assert property ((busy && q_r == 2'h2 && op_r == impse_pkg::OP_SUB
      && {1'b0, acc_r} > {1'b0, opnd_r} + {8'h00, !flags_r.c} && !sum[7])
      |=> flags_r.c && !flags_r.n && !flags_r.z) else $error("positive result flags wrong");
   a_push_fp_dec: assert property ((busy && last_q && op_r == impse_pkg::OP_PUSH)
      |=> fp_r == $past(fp_r) - 12'h001) else $error("push did not decrement pointer");
   a_flags_kept: assert property ((busy && op_r != impse_pkg::OP_SUB && q_r == 2'h2)
      |=> $stable(flags_r)) else $error("flags changed on move or push");
   a_ind_src_zero: assert property ((busy && !cyc_r && q_r == 2'h1
      && op_r == impse_pkg::OP_MOVE && addr.src_ind) |=> opnd_r == 8'h00)
      else $error("indirect source did not read zero");
   a_ind_dst_nop: assert property ((busy && op_r == impse_pkg::OP_MOVE && addr.dst_ind)
      |-> !exe_we) else $error("indirect destination was written");
   a_ext_gate: assert property (!ext_en_r && busy
      |-> op_r inside {impse_pkg::OP_SUB, impse_pkg::OP_NOP}) else $error("ext op ran while disabled");
   a_dst_sel_w: assert property ((busy && op_r == impse_pkg::OP_SUB && !ir0_r[9])
      |-> !exe_we) else $error("d=0 subtract wrote memory");

endmodule : impse_exec
